// *** bench/fcr_link_checker.sv ***
// link protocol checks between the two ends
`timescale 1ns/1ps
module fcr_link_checker #(
    parameter int OUT_WORDS = fcr_pkg::OUT_WORDS,
    parameter int IN_WORDS = fcr_pkg::IN_WORDS
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst_b,
    // link signals
    input wire logic i_req,
    input wire logic i_wr,
    input wire logic i_byte_mode,
    input wire logic i_in_space,
    input wire logic [6:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_ack,
    input wire logic i_err,
    input wire logic [15:0] i_rdata
);
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_b);

    property p_ack_pulse;
        i_ack |=> !i_ack;
    endproperty
    property p_ack_timing;
        $rose(i_req) |=> i_ack;
    endproperty
    property p_req_cycle;
        i_ack |-> i_req ##1 !i_req;
    endproperty
    property p_rdata_hold;
        !i_ack |-> $stable(i_rdata);
    endproperty
    property p_sp_range;
        i_ack && i_wr && !i_in_space
            && (i_byte_mode ? i_addr == fcr_pkg::BYTE_SET_POINT : i_addr == fcr_pkg::WORD_SET_POINT)
            && i_wdata > fcr_pkg::SET_POINT_MAX |-> i_err;
    endproperty
    property p_scale_range;
        i_ack && i_wr && !i_in_space
            && (i_byte_mode ? i_addr == fcr_pkg::BYTE_OUT_SCALE : i_addr == fcr_pkg::WORD_OUT_SCALE)
            && i_wdata > fcr_pkg::OUT_SCALE_MAX |-> i_err;
    endproperty
    property p_in_write;
        i_ack && i_wr && i_in_space |-> i_err;
    endproperty
    property p_odd_byte;
        i_ack && i_byte_mode && i_addr[0] |-> i_err;
    endproperty
    property p_out_bound;
        i_ack && !i_in_space && !i_byte_mode && i_addr >= OUT_WORDS |-> i_err;
    endproperty
    property p_in_bound;
        i_ack && i_in_space && !i_byte_mode && i_addr >= IN_WORDS |-> i_err;
    endproperty
    property p_err_with_ack;
        i_err |-> i_ack;
    endproperty

    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack longer than one cycle");
    a_ack_timing: assert property (p_ack_timing)
        else $error("ack not one cycle after request");
    a_req_cycle: assert property (p_req_cycle)
        else $error("request not released after ack");
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("read data changed without ack");
    a_sp_range: assert property (p_sp_range)
        else $error("set point above range accepted");
    a_scale_range: assert property (p_scale_range)
        else $error("scale above range accepted");
    a_in_write: assert property (p_in_write)
        else $error("input image write accepted");
    a_odd_byte: assert property (p_odd_byte)
        else $error("odd byte offset accepted");
    a_out_bound: assert property (p_out_bound)
        else $error("output word beyond image accepted");
    a_in_bound: assert property (p_in_bound)
        else $error("input word beyond image accepted");
    a_err_with_ack: assert property (p_err_with_ack)
        else $error("err without ack");

    c_write_ok: cover property (i_ack && i_wr && !i_err);
    c_read: cover property (i_ack && !i_wr);
    c_refused: cover property (i_ack && i_err);
endmodule : fcr_link_checker

// *** bench/fcr_test.sv ***
// apb driven test of host and device joined by the link
`timescale 1ns/1ps
module fcr_test;
    localparam logic [3:0] CW = 4'h3, CR = 4'h1, BW = 4'h7, BR = 4'h5, IR = 4'h9, IW = 4'hb;
    logic clock, rst_b, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd_q;
    logic rd_se, rw, sp_by_di, di_sp, en_by_di, di_en, sp_local, il_local, out_en;
    logic [6:0] station;
    logic [fcr_pkg::IN_WORDS*16-1:0] image;
    logic [15:0] cmd, sp, scale;
    logic [15:0] cv [5] = '{16'h0000, 16'h0002, 16'h0004, 16'h0010, 16'hffff};
    int err_total = 0;
    int cmp_count = 0;

    fcr_link_if fcr_link_if_i ();
    fcr_host fcr_host_i (.i_clock(clock), .i_rst_b(rst_b), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .link(fcr_link_if_i));
    fcr_device fcr_device_i (.i_clock(clock), .i_rst_b(rst_b), .i_station_addr(station),
        .i_rw_access(rw), .i_sp_by_di(sp_by_di), .i_di_sp_local(di_sp),
        .i_en_by_di(en_by_di), .i_di_enable(di_en), .i_in_image(image),
        .link(fcr_link_if_i), .o_cmd_word(cmd), .o_set_point(sp), .o_out_scale(scale),
        .o_sp_local(sp_local), .o_il_local(il_local), .o_out_enable(out_en));
    fcr_link_checker fcr_link_checker_i (.i_clock(clock), .i_rst_b(rst_b),
        .i_req(fcr_link_if_i.req), .i_wr(fcr_link_if_i.wr),
        .i_byte_mode(fcr_link_if_i.byte_mode), .i_in_space(fcr_link_if_i.in_space),
        .i_addr(fcr_link_if_i.addr), .i_wdata(fcr_link_if_i.wdata),
        .i_ack(fcr_link_if_i.ack), .i_err(fcr_link_if_i.err), .i_rdata(fcr_link_if_i.rdata));

    always #5 clock = ~clock;

    task automatic stop_test;
        if (err_total == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : stop_test

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // one apb transfer, idle cycle after so the next setup never collides
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd_q = prdata;
        rd_se = pslverr;
        if (n >= 50) begin
            err_total++;
            stop_test;
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask : apb

    // one link exchange; status polled until done
    task automatic link(input logic [3:0] c, input logic [6:0] a, input logic [15:0] d,
                        input logic exp_err);
        int n;
        apb(1'b1, fcr_pkg::APB_ADDR, {25'h0, a});
        apb(1'b1, fcr_pkg::APB_WDATA, {16'h0, d});
        apb(1'b1, fcr_pkg::APB_CTRL, {28'h0, c});
        n = 0;
        do begin
            apb(1'b0, fcr_pkg::APB_STATUS, 32'h0);
            n++;
        end while (rd_q[fcr_pkg::STAT_DONE_BIT] !== 1'b1 && n < 20);
        if (n >= 20) begin
            err_total++;
            stop_test;
        end
        check(rd_q[fcr_pkg::STAT_ERR_BIT], exp_err);
        apb(1'b0, fcr_pkg::APB_RDATA, 32'h0);
    endtask : link

    initial begin
        clock = 0;
        rst_b = 0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {rw, sp_by_di, di_sp, en_by_di, di_en} = 5'b1_0000;
        station = 7'h05;
        for (int k = 0; k < fcr_pkg::IN_WORDS; k++) image[16*k +: 16] = 16'ha000 + 16'(k);
        repeat (8) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        check({sp_local, il_local, out_en}, 3'b000);
        apb(1'b1, fcr_pkg::APB_STATION, 32'h0000_0005);
        apb(1'b0, fcr_pkg::APB_STATION, 32'h0000_0000);
        check(rd_q, 32'h0000_0005);
        for (int j = 0; j < 5; j++) begin
            link(CW, 7'h02, cv[j], 1'b0);
            repeat (2) @(posedge clock);
            check(cmd, cv[j] & fcr_pkg::CMD_MASK);
            check(sp_local, cv[j][1]);
            check(out_en, cv[j][2]);
            check(il_local, cv[j][4]);
            link(CR, 7'h02, 16'h0, 1'b0);
            check(rd_q, cv[j] & fcr_pkg::CMD_MASK);
        end
        link(BW, 7'h06, 16'h03ff, 1'b0);
        link(CR, 7'h03, 16'h0, 1'b0);
        check(rd_q, 32'h0000_03ff);
        link(BW, 7'h06, 16'h0400, 1'b1);
        check(sp, 16'h03ff);
        link(CW, 7'h03, 16'h01ff, 1'b0);
        check(sp, 16'h01ff);
        link(BW, 7'h08, 16'h00ff, 1'b0);
        link(CW, 7'h04, 16'h0100, 1'b1);
        check(scale, 16'h00ff);
        link(BR, 7'h04, 16'h0, 1'b0);
        check(rd_q, 32'h0000_0016);
        link(BW, 7'h05, 16'h0001, 1'b1);
        link(CW, 7'h07, 16'h1234, 1'b0);
        link(CR, 7'h07, 16'h0, 1'b0);
        check(rd_q, 32'h0000_0000);
        link(CW, 7'h08, 16'h0000, 1'b1);
        link(IR, 7'h2f, 16'h0, 1'b0);
        check(rd_q, 32'h0000_a02f);
        link(IR, 7'h30, 16'h0, 1'b1);
        link(IW, 7'h00, 16'h0001, 1'b1);
        apb(1'b1, fcr_pkg::APB_STATION, 32'h0000_0006);
        link(CR, 7'h02, 16'h0, 1'b1);
        apb(1'b1, fcr_pkg::APB_STATION, 32'h0000_0005);
        sp_by_di <= 1'b1;
        repeat (2) @(posedge clock);
        check(sp_local, 1'b1);
        rw <= 1'b0;
        repeat (2) @(posedge clock);
        check(sp_local, 1'b0);
        link(CW, 7'h02, 16'h0000, 1'b1);
        rw <= 1'b1;
        sp_by_di <= 1'b0;
        en_by_di <= 1'b1;
        repeat (2) @(posedge clock);
        check(out_en, 1'b0);
        di_en <= 1'b1;
        repeat (2) @(posedge clock);
        check(out_en, 1'b1);
        link(CW, 7'h02, 16'h0000, 1'b0);
        repeat (2) @(posedge clock);
        check(out_en, 1'b0);
        check({sp_local, il_local}, 2'b00);
        apb(1'b0, 8'h20, 32'h0);
        check(rd_se, 1'b1);
        check(rd_q, 32'h0000_0000);
        stop_test;
    end
endmodule : fcr_test

// *** core/fcr_device.sv ***
// power controller end: holding register bank and output source selection
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module fcr_device #(
    parameter int OUT_WORDS = fcr_pkg::OUT_WORDS,
    parameter int IN_WORDS = fcr_pkg::IN_WORDS
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst_b,
    // configuration
    input wire logic [6:0] i_station_addr,
    input wire logic i_rw_access,
    input wire logic i_sp_by_di,
    input wire logic i_di_sp_local,
    input wire logic i_en_by_di,
    input wire logic i_di_enable,
    // live values returned in the input image
    input wire logic [IN_WORDS*16-1:0] i_in_image,
    // link
    fcr_link_if.device link,
    // held values
    output logic [15:0] o_cmd_word,
    output logic [15:0] o_set_point,
    output logic [15:0] o_out_scale,
    // resolved sources
    output logic o_sp_local,
    output logic o_il_local,
    output logic o_out_enable
);
    // word index is seven bits wide, and the command,
    // set point and scale words must sit inside the output image
    if (OUT_WORDS < 5 || OUT_WORDS > 64) begin : g_bad_out_words
        $error("fcr_device: OUT_WORDS must be 5 to 64");
    end
    if (IN_WORDS < 1 || IN_WORDS > 64) begin : g_bad_in_words
        $error("fcr_device: IN_WORDS must be 1 to 64");
    end

    logic [15:0] cmd_ff;
    logic [15:0] nxt_cmd;
    logic [15:0] sp_ff;
    logic [15:0] nxt_sp;
    logic [15:0] scale_ff;
    logic [15:0] nxt_scale;
    logic ack_ff;
    logic nxt_ack;
    logic err_ff;
    logic nxt_err;
    logic [15:0] rdata_ff;
    logic [15:0] nxt_rdata;
    logic sp_local_ff;
    logic nxt_sp_local;
    logic il_local_ff;
    logic nxt_il_local;
    logic enable_ff;
    logic nxt_enable;

    logic [6:0] word_idx;
    logic misaligned;
    logic take;

    // one answer per request; the master drops req after the ack
    always_comb begin
        take = link.req && !ack_ff;
        misaligned = link.byte_mode && link.addr[0];
        if (link.byte_mode) begin
            word_idx = fcr_pkg::byte_to_word(link.addr);
        end else begin
            word_idx = link.addr;
        end
    end

    always_comb begin
        nxt_cmd = cmd_ff;
        nxt_sp = sp_ff;
        nxt_scale = scale_ff;
        nxt_ack = take;
        nxt_err = 1'b0;
        nxt_rdata = rdata_ff;
        if (take) begin
            nxt_rdata = 16'h0000;
            if (link.station != i_station_addr || misaligned) begin
                // wrong station still answers so the master never hangs
                nxt_err = 1'b1;
            end else if (link.in_space) begin
                if (link.wr || int'(word_idx) >= IN_WORDS) begin
                    nxt_err = 1'b1;
                end else begin
                    nxt_rdata = i_in_image[int'(word_idx)*16 +: 16];
                end
            end else if (int'(word_idx) >= OUT_WORDS) begin
                nxt_err = 1'b1;
            end else if (!link.wr) begin
                case (word_idx)
                    fcr_pkg::WORD_CMD: begin
                        nxt_rdata = cmd_ff;
                    end
                    fcr_pkg::WORD_SET_POINT: begin
                        nxt_rdata = sp_ff;
                    end
                    fcr_pkg::WORD_OUT_SCALE: begin
                        nxt_rdata = scale_ff;
                    end
                    default: begin
                        nxt_rdata = 16'h0000;
                    end
                endcase
            end else if (!i_rw_access) begin
                nxt_err = 1'b1;
            end else begin
                case (word_idx)
                    fcr_pkg::WORD_CMD: begin
                        nxt_cmd = link.wdata & fcr_pkg::CMD_MASK;
                    end
                    fcr_pkg::WORD_SET_POINT: begin
                        if (link.wdata > fcr_pkg::SET_POINT_MAX) begin
                            nxt_err = 1'b1;
                        end else begin
                            nxt_sp = link.wdata;
                        end
                    end
                    fcr_pkg::WORD_OUT_SCALE: begin
                        if (link.wdata > fcr_pkg::OUT_SCALE_MAX) begin
                            nxt_err = 1'b1;
                        end else begin
                            nxt_scale = link.wdata;
                        end
                    end
                    default: begin
                        // spare words take writes silently
                        nxt_err = 1'b0;
                    end
                endcase
            end
        end
    end

    // once the port may write, the set point source follows the command word; the enable needs its command bit and, with i_en_by_di, i_di_enable too
    always_comb begin
        if (i_rw_access) begin
            nxt_sp_local = cmd_ff[fcr_pkg::CMD_SP_LOCAL_BIT];
            if (i_en_by_di) begin
                nxt_enable = i_di_enable && cmd_ff[fcr_pkg::CMD_ENABLE_BIT];
            end else begin
                nxt_enable = cmd_ff[fcr_pkg::CMD_ENABLE_BIT];
            end
        end else begin
            nxt_sp_local = i_sp_by_di ? i_di_sp_local : cmd_ff[fcr_pkg::CMD_SP_LOCAL_BIT];
            nxt_enable = i_en_by_di ? i_di_enable : cmd_ff[fcr_pkg::CMD_ENABLE_BIT];
        end
        nxt_il_local = cmd_ff[fcr_pkg::CMD_IL_LOCAL_BIT];
    end

    // reset clears the command word, leaving both sources on analog inputs
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cmd_ff <= fcr_pkg::HOLD_RESET;
            sp_ff <= fcr_pkg::HOLD_RESET;
            scale_ff <= fcr_pkg::HOLD_RESET;
            ack_ff <= 1'b0;
            err_ff <= 1'b0;
            rdata_ff <= 16'h0000;
            sp_local_ff <= 1'b0;
            il_local_ff <= 1'b0;
            enable_ff <= 1'b0;
        end else begin
            cmd_ff <= nxt_cmd;
            sp_ff <= nxt_sp;
            scale_ff <= nxt_scale;
            ack_ff <= nxt_ack;
            err_ff <= nxt_err;
            rdata_ff <= nxt_rdata;
            sp_local_ff <= nxt_sp_local;
            il_local_ff <= nxt_il_local;
            enable_ff <= nxt_enable;
        end
    end

    // only a plain word exchange is offered, no acyclic services
    assign link.ack = ack_ff;
    assign link.err = err_ff;
    assign link.rdata = rdata_ff;
    assign o_cmd_word = cmd_ff;
    assign o_set_point = sp_ff;
    assign o_out_scale = scale_ff;
    assign o_sp_local = sp_local_ff;
    assign o_il_local = il_local_ff;
    assign o_out_enable = enable_ff;
endmodule : fcr_device

// *** core/fcr_host.sv ***
// fieldbus master end: apb controlled single word exchange engine
`timescale 1ns/1ps
module fcr_host (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst_b,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // link
    fcr_link_if.master link
);
    typedef enum logic [1:0] {
        FCR_IDLE = 2'b01,
        FCR_WAIT = 2'b10
    } fcr_state_e;

    fcr_state_e state_ff;
    fcr_state_e nxt_state;
    logic wr_ff;
    logic nxt_wr;
    logic byte_ff;
    logic nxt_byte;
    logic in_ff;
    logic nxt_in;
    logic [6:0] addr_ff;
    logic [6:0] nxt_addr;
    logic [15:0] wdata_ff;
    logic [15:0] nxt_wdata;
    logic [6:0] station_ff;
    logic [6:0] nxt_station;
    logic [15:0] rdata_ff;
    logic [15:0] nxt_rdata;
    logic done_ff;
    logic nxt_done;
    logic err_ff;
    logic nxt_err;

    logic apb_wr;
    logic mapped;
    logic busy;

    always_comb begin
        apb_wr = i_psel && i_penable && i_pwrite;
        busy = (state_ff == FCR_WAIT);
        case (i_paddr)
            fcr_pkg::APB_CTRL, fcr_pkg::APB_ADDR, fcr_pkg::APB_WDATA,
            fcr_pkg::APB_STATUS, fcr_pkg::APB_RDATA, fcr_pkg::APB_STATION: begin
                mapped = 1'b1;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    // setup writes while busy are dropped so the request stays stable
    always_comb begin
        nxt_state = state_ff;
        nxt_wr = wr_ff;
        nxt_byte = byte_ff;
        nxt_in = in_ff;
        nxt_addr = addr_ff;
        nxt_wdata = wdata_ff;
        nxt_station = station_ff;
        nxt_rdata = rdata_ff;
        nxt_done = done_ff;
        nxt_err = err_ff;
        case (state_ff)
            FCR_IDLE: begin
                if (apb_wr && i_paddr == fcr_pkg::APB_CTRL) begin
                    nxt_wr = i_pwdata[fcr_pkg::CTRL_WRITE_BIT];
                    nxt_byte = i_pwdata[fcr_pkg::CTRL_BYTE_BIT];
                    nxt_in = i_pwdata[fcr_pkg::CTRL_INPUT_BIT];
                    if (i_pwdata[fcr_pkg::CTRL_GO_BIT]) begin
                        nxt_done = 1'b0;
                        nxt_err = 1'b0;
                        nxt_state = FCR_WAIT;
                    end
                end
                if (apb_wr && i_paddr == fcr_pkg::APB_ADDR) begin
                    nxt_addr = i_pwdata[6:0];
                end
                if (apb_wr && i_paddr == fcr_pkg::APB_WDATA) begin
                    nxt_wdata = i_pwdata[15:0];
                end
                if (apb_wr && i_paddr == fcr_pkg::APB_STATION) begin
                    nxt_station = i_pwdata[6:0];
                end
            end
            FCR_WAIT: begin
                // waits for the answer as long as it takes
                if (link.ack) begin
                    nxt_done = 1'b1;
                    nxt_err = link.err;
                    nxt_rdata = link.wr ? rdata_ff : link.rdata;
                    nxt_state = FCR_IDLE;
                end
            end
            default: begin
                nxt_state = FCR_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_ff <= FCR_IDLE;
            wr_ff <= 1'b0;
            byte_ff <= 1'b0;
            in_ff <= 1'b0;
            addr_ff <= 7'h00;
            wdata_ff <= 16'h0000;
            station_ff <= 7'h00;
            rdata_ff <= 16'h0000;
            done_ff <= 1'b0;
            err_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            wr_ff <= nxt_wr;
            byte_ff <= nxt_byte;
            in_ff <= nxt_in;
            addr_ff <= nxt_addr;
            wdata_ff <= nxt_wdata;
            station_ff <= nxt_station;
            rdata_ff <= nxt_rdata;
            done_ff <= nxt_done;
            err_ff <= nxt_err;
        end
    end

    always_comb begin
        case (i_paddr)
            fcr_pkg::APB_CTRL: begin
                o_prdata = {28'h000_0000, in_ff, byte_ff, wr_ff, busy};
            end
            fcr_pkg::APB_ADDR: begin
                o_prdata = {25'h000_0000, addr_ff};
            end
            fcr_pkg::APB_WDATA: begin
                o_prdata = {16'h0000, wdata_ff};
            end
            fcr_pkg::APB_STATUS: begin
                o_prdata = {29'h0000_0000, err_ff, done_ff, busy};
            end
            fcr_pkg::APB_RDATA: begin
                o_prdata = {16'h0000, rdata_ff};
            end
            fcr_pkg::APB_STATION: begin
                o_prdata = {25'h000_0000, station_ff};
            end
            default: begin
                o_prdata = 32'h0000_0000;
            end
        endcase
    end

    // values are scaled by software before they reach the wdata register
    assign o_pready = 1'b1;
    assign o_pslverr = i_psel && i_penable && !mapped;
    assign link.req = busy;
    assign link.wr = wr_ff;
    assign link.byte_mode = byte_ff;
    assign link.in_space = in_ff;
    assign link.station = station_ff;
    assign link.addr = addr_ff;
    assign link.wdata = wdata_ff;
endmodule : fcr_host

// *** core/fcr_link_if.sv ***
// link between the fieldbus master and the power controller register bank
`timescale 1ns/1ps
interface fcr_link_if;
    logic req;
    logic wr;
    logic byte_mode;
    logic in_space;
    logic [6:0] station;
    logic [6:0] addr;
    logic [15:0] wdata;
    logic ack;
    logic err;
    logic [15:0] rdata;

    modport master (
        output req, wr, byte_mode, in_space, station, addr, wdata,
        input ack, err, rdata
    );
    modport device (
        input req, wr, byte_mode, in_space, station, addr, wdata,
        output ack, err, rdata
    );
endinterface : fcr_link_if

// *** core/fcr_pkg.sv ***
// constants shared by both ends of the fieldbus command register link
package fcr_pkg;
    localparam int OUT_WORDS = 8;
    localparam int IN_WORDS = 48;
    localparam int ADDR_W = 7;
    localparam int DATA_W = 16;
    localparam int STATION_W = 7;

    // holding words, word addressing
    localparam logic [6:0] WORD_CMD = 7'h02;
    localparam logic [6:0] WORD_SET_POINT = 7'h03;
    localparam logic [6:0] WORD_OUT_SCALE = 7'h04;
    // same words, byte addressing of the cyclic bus
    localparam logic [6:0] BYTE_CMD = 7'h04;
    localparam logic [6:0] BYTE_SET_POINT = 7'h06;
    localparam logic [6:0] BYTE_OUT_SCALE = 7'h08;

    // command word fields
    localparam int CMD_SP_LOCAL_BIT = 1;
    localparam int CMD_ENABLE_BIT = 2;
    localparam int CMD_IL_LOCAL_BIT = 4;
    localparam logic [15:0] CMD_MASK = 16'h0016;

    // ranges and reset values
    localparam logic [15:0] SET_POINT_MAX = 16'h03ff;
    localparam logic [15:0] OUT_SCALE_MAX = 16'h00ff;
    localparam logic [15:0] HOLD_RESET = 16'h0000;

    // controller registers on apb, byte addresses
    localparam logic [7:0] APB_CTRL = 8'h00;
    localparam logic [7:0] APB_ADDR = 8'h04;
    localparam logic [7:0] APB_WDATA = 8'h08;
    localparam logic [7:0] APB_STATUS = 8'h0c;
    localparam logic [7:0] APB_RDATA = 8'h10;
    localparam logic [7:0] APB_STATION = 8'h14;
    localparam int CTRL_GO_BIT = 0;
    localparam int CTRL_WRITE_BIT = 1;
    localparam int CTRL_BYTE_BIT = 2;
    localparam int CTRL_INPUT_BIT = 3;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_DONE_BIT = 1;
    localparam int STAT_ERR_BIT = 2;

    // byte offset on the cyclic bus to word index
    function automatic logic [6:0] byte_to_word(input logic [6:0] byte_off);
        byte_to_word = {1'b0, byte_off[6:1]};
    endfunction : byte_to_word
endpackage : fcr_pkg
